// ### sim/gamma_bank_i2c_register_mode_tb.sv
`timescale 1ns/100ps
module gamma_bank_i2c_register_mode_tb;
    import gbi_pkg::*;
    localparam logic [6:0] DEV = 7'h2A;  // Arbitrary target address
    logic         mclk, reset, clkEn, modeSel, sdaOut, dutSdaOe, gammaEn;
    logic         mSclOe, mSdaOe, obsValid;
    logic [7:0]   ctrlOut, obsData, shCtrl, expByte;
    logic [111:0] bankA, bankB;
    logic [7:0]   shA [1:14];
    logic [7:0]   shB [1:14];
    logic [7:0]   wd [0:15];
    logic [6:0]   bad [0:2];
    logic [7:0]   expQ [$];
    int           n_mismatch = 0, check_count = 0, cycles = 0, seed = 32'h41E1;
    wire logic    sdaLine = ~(mSdaOe | (dutSdaOe & ~sdaOut));
    gbi_target #(.NUM_LEVELS(14), .TARGET_ADDR(DEV)) u_dut (
        .mclk(mclk), .reset(reset), .clkEn(clkEn), .sclIn(~mSclOe), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(dutSdaOe), .interfaceModeSelect(modeSel),
        .gammaOutputsEnable(gammaEn), .bankSelectControl(ctrlOut),
        .levelBankA(bankA), .levelBankB(bankB));
    gbi_i2c_ctrl u_ctrl (.mclk(mclk), .sdaLine(sdaLine), .sclOe(mSclOe), .sdaOe(mSdaOe),
        .obsData(obsData), .obsValid(obsValid));
    task automatic compareByte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : compareByte
    task automatic compareBit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : compareBit
    task automatic final_report;
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic checkBanks;
        for (int i = 1; i <= 14; i++) begin
            compareByte("bank A entry", shA[i], bankA[(i-1)*8 +: 8]);
            compareByte("bank B entry", shB[i], bankB[(i-1)*8 +: 8]);
        end
        compareByte("control", shCtrl, ctrlOut);
    endtask : checkBanks
    // Pointer saturates past the last entry, so overflow bytes land nowhere
    task automatic doWrite(input logic [7:0] ra, input int n);
        int p;
        p = ra;
        for (int i = 0; i < n + 2; i++) expQ.push_back(8'h01);
        for (int i = 0; i < n; i++) begin
            if (p == 0) shCtrl = wd[i];
            else if (p <= 14 && shCtrl[WRITE_BANK_BIT]) shB[p] = wd[i];
            else if (p <= 14) shA[p] = wd[i];
            p = (p >= 15) ? 15 : p + 1;
        end
        u_ctrl.writeRegs(DEV, ra, n, wd);
    endtask : doWrite
    task automatic doRead(input logic withReg, input logic [7:0] ra, input int n);
        int p;
        p = withReg ? ra : 1;
        for (int i = 0; i < (withReg ? 3 : 1); i++) expQ.push_back(8'h01);
        for (int i = 0; i < n; i++) begin
            if (p == 0) expQ.push_back(shCtrl);
            else if (p <= 14) expQ.push_back(shCtrl[READ_BANK_BIT] ? shB[p] : shA[p]);
            else expQ.push_back(8'hFF);
            p = (p >= 15) ? 15 : p + 1;
        end
        u_ctrl.readRegs(DEV, withReg, ra, n);
    endtask : doRead
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
        if (obsValid) begin
            expByte = (expQ.size() > 0) ? expQ.pop_front() : 8'hXX;
            compareByte("bus byte", expByte, obsData);
        end
    end
    initial begin
        reset = 1'b1;
        clkEn = 1'b1;
        modeSel = MODE_REGISTER;
        shCtrl = 8'h00;
        for (int i = 1; i <= 14; i++) shA[i] = 8'h00;
        for (int i = 1; i <= 14; i++) shB[i] = 8'h00;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        repeat (5) @(posedge mclk);
        checkBanks();
        compareBit("outputs enable", 1'b0, gammaEn);
        for (int i = 0; i < 16; i++) wd[i] = 8'($random(seed));
        doWrite(8'h0D, 3);
        checkBanks();
        compareBit("outputs enable", 1'b0, gammaEn);
        wd[0] = 8'h02;
        doWrite(CTRL_ADDR, 1);
        for (int i = 0; i < 16; i++) wd[i] = 8'($random(seed));
        doWrite(LEVEL_FIRST_ADDR, 16);
        checkBanks();
        compareBit("outputs enable", 1'b1, gammaEn);
        u_ctrl.extraLow = 3;
        wd[0] = 8'h04;
        doWrite(CTRL_ADDR, 1);
        doRead(1'b1, 8'h0C, 4);
        doRead(1'b1, 8'h03, 2);
        doRead(1'b1, CTRL_ADDR, 2);
        u_ctrl.extraLow = 0;
        bad[0] = DEV ^ 7'h01;
        bad[1] = GENERAL_CALL;
        bad[2] = {TEN_BIT_PREFIX, 2'h1};
        foreach (bad[k]) begin
            expQ.push_back(8'h00);
            u_ctrl.writeRegs(bad[k], LEVEL_FIRST_ADDR, 2, wd);
        end
        checkBanks();
        // A frozen target must neither answer nor store
        clkEn <= 1'b0;
        expQ.push_back(8'h00);
        u_ctrl.writeRegs(DEV, LEVEL_FIRST_ADDR, 2, wd);
        clkEn <= 1'b1;
        checkBanks();
        modeSel <= 1'b1;
        repeat (4) @(posedge mclk);
        // Standard-mode write: control byte first, then entries from the first one
        for (int i = 0; i < 5; i++) expQ.push_back(8'h01);
        shCtrl = 8'h04;
        for (int i = 1; i <= 3; i++) shA[i] = wd[i-1];
        u_ctrl.writeRegs(DEV, shCtrl, 3, wd);
        checkBanks();
        doRead(1'b0, LEVEL_FIRST_ADDR, 15);
        modeSel <= MODE_REGISTER;
        // Mid-run reset must clear control, levels and the output enable
        reset <= 1'b1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        repeat (5) @(posedge mclk);
        shCtrl = 8'h00;
        for (int i = 1; i <= 14; i++) shA[i] = 8'h00;
        for (int i = 1; i <= 14; i++) shB[i] = 8'h00;
        checkBanks();
        compareBit("outputs enable", 1'b0, gammaEn);
        compareBit("queue drained", 1'b1, expQ.size() == 0);
        final_report();
    end
endmodule : gamma_bank_i2c_register_mode_tb

// ### sim/gbi_i2c_ctrl.sv
`timescale 1ns/100ps
module gbi_i2c_ctrl (
    input  wire logic       mclk,
    input  wire logic       sdaLine,
    output logic            sclOe,
    output logic            sdaOe,
    output logic [7:0]      obsData,
    output logic            obsValid
);
    // Stretches the low phase to play a slow controller
    int extraLow = 0;
    initial begin
        sclOe    = 1'b0;
        sdaOe    = 1'b0;
        obsData  = 8'h00;
        obsValid = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic report(input logic [7:0] v);
        obsData  <= v;
        obsValid <= 1'b1;
        tick(1);
        obsValid <= 1'b0;
    endtask : report
    // Data moves mid-low so the target's late ACK release never races the rise
    task automatic bitCyc(input logic low, output logic level);
        tick(3);
        sdaOe <= low;
        tick(2 + extraLow);
        sclOe <= 1'b0;
        tick(2);
        level = sdaLine;
        tick(1);
        sclOe <= 1'b1;
    endtask : bitCyc
    task automatic xfer(input logic [7:0] tx, input logic rd, input logic ackOut,
                        output logic [7:0] rx);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitCyc(~tx[i], b);
            rx[i] = b;
        end
        bitCyc(ackOut, b);
        // Read bytes are reported by the caller; a data byte may well be 0xFF
        if (!rd) report({7'h00, ~b});
    endtask : xfer
    task automatic start;
        sdaOe <= 1'b1;
        tick(4);
        sclOe <= 1'b1;
    endtask : start
    task automatic stop;
        tick(3);
        sdaOe <= 1'b1;
        tick(4);
        sclOe <= 1'b0;
        tick(4);
        sdaOe <= 1'b0;
        tick(8);
    endtask : stop
    task automatic writeRegs(input logic [6:0] dev, input logic [7:0] ra, input int n,
                             input logic [7:0] d [0:15]);
        logic [7:0] rx;
        start();
        xfer({dev, 1'b0}, 1'b0, 1'b0, rx);
        if (obsData[0]) begin
            xfer(ra, 1'b0, 1'b0, rx);
            for (int i = 0; i < n; i++) xfer(d[i], 1'b0, 1'b0, rx);
        end
        stop();
    endtask : writeRegs
    task automatic readRegs(input logic [6:0] dev, input logic withReg, input logic [7:0] ra,
                            input int n);
        logic [7:0] rx;
        start();
        if (withReg) begin
            xfer({dev, 1'b0}, 1'b0, 1'b0, rx);
            xfer(ra, 1'b0, 1'b0, rx);
            tick(3);
            sdaOe <= 1'b0;
            tick(4);
            sclOe <= 1'b0;
            tick(4);
            sdaOe <= 1'b1;
            tick(4);
            sclOe <= 1'b1;
        end
        xfer({dev, 1'b1}, 1'b0, 1'b0, rx);
        for (int i = 0; i < n; i++) begin
            xfer(8'hFF, 1'b1, i != n - 1, rx);
            report(rx);
        end
        stop();
    endtask : readRegs
endmodule : gbi_i2c_ctrl

// ### src/gbi_pkg.sv
// Notes on behaviour
// - Mode select low picks register mode: target address, register address, data.
// - Burst write stores first byte at given address, then advances by one.
// - Bytes past level entry fourteen are dropped; the bus transfer still completes.
// - Burst from entry thirteen with more than two bytes updates only 13, 14.
// - Register-mode burst read returns entries up to fourteen, then 0xFF each.
// - Short burst read gives consecutive entries until the controller stops taking.
// - Standard-mode read returns entries one to fourteen, then 0xFF.
// - Acknowledge pulls data low during the ninth clock; read data bits of zero also pull it low; lines otherwise inputs.
// - General call address ignored; no CBUS formats.
// - Only seven-bit target addresses recognised; ten-bit formats are not.
// - Repeated START accepted, direction changes, register pointer kept.
// - Control bit one picks write bank, bit two read bank; reset clears both.
// - Outputs stay off until both banks received at least two data bytes.
package gbi_pkg;
    localparam logic [7:0] CTRL_ADDR        = 8'h00;
    localparam logic [7:0] LEVEL_FIRST_ADDR = 8'h01;
    localparam logic [7:0] LEVEL_LAST_ADDR  = 8'h0E;
    localparam logic [3:0] PTR_PAST_LAST    = 4'hF;
    localparam logic [7:0] CTRL_RESET       = 8'h00;
    localparam logic [7:0] LEVEL_RESET      = 8'h00;
    localparam logic [7:0] INVALID_BYTE     = 8'hFF;
    localparam int         WRITE_BANK_BIT   = 1;
    localparam int         READ_BANK_BIT    = 2;
    localparam logic       MODE_REGISTER    = 1'b0;
    localparam logic [1:0] MIN_BANK_WRITES  = 2'h2;
    localparam logic [6:0] GENERAL_CALL     = 7'h00;
    localparam logic [4:0] TEN_BIT_PREFIX   = 5'h1E;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SKIP, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
    } gbi_state_e;
endpackage : gbi_pkg

// ### src/gbi_target.sv
`timescale 1ns/100ps
module gbi_target
    import gbi_pkg::*;
#(
    parameter int         NUM_LEVELS  = 14,
    parameter logic [6:0] TARGET_ADDR = 7'h2A  // Arbitrary default
) (
    input  wire logic                      mclk,
    input  wire logic                      reset,
    input  wire logic                      clkEn,
    input  wire logic                      sclIn,
    input  wire logic                      sdaIn,
    output wire logic                      sdaOut,
    output wire logic                      sdaOe,
    input  wire logic                      interfaceModeSelect,
    output wire logic                      gammaOutputsEnable,
    output wire logic [7:0]                bankSelectControl,
    output wire logic [NUM_LEVELS*8-1:0]   levelBankA,
    output wire logic [NUM_LEVELS*8-1:0]   levelBankB
);
    generate
        if (NUM_LEVELS < 1 || NUM_LEVELS > 14) begin : g_bad_levels
            $error("NUM_LEVELS must be 1 to 14");
        end
        if (TARGET_ADDR == GENERAL_CALL || TARGET_ADDR[6:2] == TEN_BIT_PREFIX) begin : g_bad_addr
            $error("TARGET_ADDR is reserved");
        end
    endgenerate

    typedef struct packed {
        logic [2:0]                            sclS;
        logic [2:0]                            sdaS;
        logic [2:0]                            modeS;
        logic                                  sclF;
        logic                                  sdaF;
        logic                                  modeF;
        gbi_state_e                            st;
        logic [3:0]                            bitCnt;
        logic [7:0]                            shift;
        logic                                  rw;
        logic                                  nack;
        logic [3:0]                            ptr;
        logic [7:0]                            ctrl;
        logic [1:0][NUM_LEVELS-1:0][7:0]       lvl;
        logic [1:0][1:0]                       wrCnt;
        logic                                  outEn;
        logic                                  sdaOe;
    } gbi_regs_s;

    gbi_regs_s q;
    gbi_regs_s n;
    logic      sclNew;
    logic      sdaNew;
    logic      sclRise;
    logic      sclFall;
    logic      startEv;
    logic      stopEv;
    logic      loadEv;
    logic [3:0] rdPtr;

    // Value presented for a pointer; beyond the last entry reads invalid
    function automatic logic [7:0] byteAt(input gbi_regs_s s, input logic [3:0] p);
        logic [3:0] idx;
        idx = p - 4'h1;
        if (p == CTRL_ADDR[3:0])
            byteAt = s.ctrl;
        else if (p <= 4'(NUM_LEVELS))
            byteAt = s.lvl[s.ctrl[READ_BANK_BIT]][idx];
        else
            byteAt = INVALID_BYTE;
    endfunction : byteAt

    // Saturates one past the last entry so long bursts never wrap
    function automatic logic [3:0] nextPtr(input logic [3:0] p);
        nextPtr = (p >= 4'(NUM_LEVELS)) ? PTR_PAST_LAST : p + 4'h1;
    endfunction : nextPtr

    always_comb begin
        n       = q;
        loadEv  = 1'b0;
        rdPtr   = q.ptr;
        n.sclS  = {q.sclS[1:0], sclIn};
        n.sdaS  = {q.sdaS[1:0], sdaIn};
        n.modeS = {q.modeS[1:0], interfaceModeSelect};
        // A change counts only once the second and third stages agree
        sclNew  = (q.sclS[1] == q.sclS[2]) ? q.sclS[2] : q.sclF;
        sdaNew  = (q.sdaS[1] == q.sdaS[2]) ? q.sdaS[2] : q.sdaF;
        if (q.modeS[1] == q.modeS[2]) begin
            n.modeF = q.modeS[2];
        end
        n.sclF  = sclNew;
        n.sdaF  = sdaNew;
        sclRise = sclNew & ~q.sclF;
        sclFall = ~sclNew & q.sclF;
        startEv = q.sclF & sclNew & q.sdaF & ~sdaNew;
        stopEv  = q.sclF & sclNew & ~q.sdaF & sdaNew;
        if (startEv) begin
            n.st     = ST_ADDR;
            n.bitCnt = 4'h0;
            n.sdaOe  = 1'b0;
        end else if (stopEv) begin
            n.st    = ST_IDLE;
            n.sdaOe = 1'b0;
        end else begin
            unique case (q.st)
                ST_IDLE, ST_SKIP: begin
                    n.sdaOe = 1'b0;
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (sclRise) begin
                        n.shift  = {q.shift[6:0], sdaNew};
                        n.bitCnt = q.bitCnt + 4'h1;
                    end else if (sclFall && q.bitCnt == 4'h8) begin
                        n.bitCnt = 4'h0;
                        n.sdaOe  = 1'b1;
                        if (q.st == ST_ADDR) begin
                            if (q.shift[7:1] == TARGET_ADDR) begin
                                n.rw = q.shift[0];
                                n.st = ST_ADDR_ACK;
                            end else begin
                                n.sdaOe = 1'b0;
                                n.st    = ST_SKIP;
                            end
                        end else if (q.st == ST_REG) begin
                            n.ptr = (q.shift > 8'(NUM_LEVELS)) ? PTR_PAST_LAST : q.shift[3:0];
                            n.st  = ST_REG_ACK;
                        end else begin
                            n.st  = ST_WDATA_ACK;
                            n.ptr = nextPtr(q.ptr);
                            if (q.ptr == CTRL_ADDR[3:0]) begin
                                n.ctrl = q.shift;
                            end else if (q.ptr <= 4'(NUM_LEVELS)) begin
                                n.lvl[q.ctrl[WRITE_BANK_BIT]][q.ptr - 4'h1] = q.shift;
                                if (q.wrCnt[q.ctrl[WRITE_BANK_BIT]] != MIN_BANK_WRITES) begin
                                    n.wrCnt[q.ctrl[WRITE_BANK_BIT]] =
                                        q.wrCnt[q.ctrl[WRITE_BANK_BIT]] + 2'h1;
                                end
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
                    if (sclFall) begin
                        n.sdaOe = 1'b0;
                        if (q.st != ST_ADDR_ACK) begin
                            n.st = ST_WDATA;
                        end else if (!q.rw) begin
                            // register mode takes an address byte first
                            if (q.modeF == MODE_REGISTER) begin
                                n.st = ST_REG;
                            end else begin
                                n.ptr = CTRL_ADDR[3:0];
                                n.st  = ST_WDATA;
                            end
                        end else begin
                            // standard read starts at first entry
                            rdPtr  = (q.modeF == MODE_REGISTER) ? q.ptr : LEVEL_FIRST_ADDR[3:0];
                            loadEv = 1'b1;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclFall) begin
                        n.bitCnt = q.bitCnt + 4'h1;
                        if (q.bitCnt == 4'h7) begin
                            n.sdaOe = 1'b0;
                            n.st    = ST_RACK;
                        end else begin
                            n.shift = {q.shift[6:0], 1'b0};
                            n.sdaOe = ~q.shift[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (sclRise) begin
                        n.nack = sdaNew;
                    end else if (sclFall) begin
                        if (q.nack) begin
                            n.st = ST_SKIP;
                        end else begin
                            loadEv = 1'b1;
                        end
                    end
                end
            endcase
        end
        // sequential read, invalid past the last entry
        if (loadEv) begin
            n.shift  = byteAt(q, rdPtr);
            n.ptr    = nextPtr(rdPtr);
            n.sdaOe  = ~n.shift[7];
            n.bitCnt = 4'h0;
            n.st     = ST_RDATA;
        end
        n.outEn = q.outEn | (q.wrCnt[0] == MIN_BANK_WRITES && q.wrCnt[1] == MIN_BANK_WRITES);
        if (!clkEn) begin
            n = q;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q       <= '0;
            q.sclS  <= 3'h7;
            q.sdaS  <= 3'h7;
            q.sclF  <= 1'b1;
            q.sdaF  <= 1'b1;
            q.st    <= ST_IDLE;
            q.ctrl  <= CTRL_RESET;
            q.lvl   <= {(2*NUM_LEVELS){LEVEL_RESET}};
        end else begin
            q <= n;
        end
    end

    // Open drain: only ever pulls low
    assign sdaOut             = 1'b0;
    assign sdaOe              = q.sdaOe;
    assign gammaOutputsEnable = q.outEn;
    assign bankSelectControl  = q.ctrl;
    assign levelBankA         = q.lvl[0];
    assign levelBankB         = q.lvl[1];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_ackOnly;
        q.sdaOe |-> q.st inside {ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK, ST_RDATA};
    endproperty
    a_ackOnly: assert property (p_ackOnly) else $error("sda driven outside slot");

    property p_ctrlReset;
        reset ##1 !reset |-> q.ctrl == CTRL_RESET;
    endproperty
    a_ctrlReset: assert property (@(posedge mclk) disable iff (1'b0) p_ctrlReset)
        else $error("control not cleared by reset");

    property p_outEnGate;
        $rose(q.outEn) |-> $past(q.wrCnt[0]) == MIN_BANK_WRITES
            && $past(q.wrCnt[1]) == MIN_BANK_WRITES;
    endproperty
    a_outEnGate: assert property (p_outEnGate) else $error("outputs enabled early");

    property p_dropPast;
        q.st == ST_WDATA_ACK && $past(q.st) == ST_WDATA && $past(q.ptr) > 4'(NUM_LEVELS)
            |-> q.lvl == $past(q.lvl);
    endproperty
    a_dropPast: assert property (p_dropPast) else $error("late byte stored");

    // A frozen or reset cycle loads nothing, so only a real load is checked
    property p_invalidRead;
        $past(loadEv && clkEn && !reset && rdPtr > 4'(NUM_LEVELS)) |-> q.shift == INVALID_BYTE;
    endproperty
    a_invalidRead: assert property (p_invalidRead) else $error("invalid byte not 0xFF");

    property p_addrMatch;
        q.st == ST_ADDR_ACK |-> q.shift[7:1] == TARGET_ADDR;
    endproperty
    a_addrMatch: assert property (p_addrMatch) else $error("foreign address");

    property p_ptrAdvance;
        q.st == ST_WDATA_ACK && $past(q.st) == ST_WDATA
            |-> q.ptr == nextPtr($past(q.ptr));
    endproperty
    a_ptrAdvance: assert property (p_ptrAdvance) else $error("pointer did not advance");

    property p_startKeepsPtr;
        clkEn && startEv |=> q.st == ST_ADDR && q.ptr == $past(q.ptr);
    endproperty
    a_startKeepsPtr: assert property (p_startKeepsPtr) else $error("start lost ptr");

    property p_stdRead;
        loadEv && clkEn && q.st == ST_ADDR_ACK && q.modeF != MODE_REGISTER
            |=> q.shift == $past(q.lvl[q.ctrl[READ_BANK_BIT]][0]);
    endproperty
    a_stdRead: assert property (p_stdRead) else $error("std read misplaced");

    property p_regMode;
        q.st == ST_ADDR_ACK && !q.rw && sclFall && clkEn && !startEv && !stopEv
            && q.modeF == MODE_REGISTER |=> q.st == ST_REG;
    endproperty
    a_regMode: assert property (p_regMode) else $error("reg byte skipped");

    c_write: cover property (q.st == ST_WDATA_ACK ##[1:400] q.st == ST_WDATA_ACK);
    c_read:  cover property (q.st == ST_RACK ##[1:400] q.st == ST_RDATA);
    c_outEn: cover property ($rose(q.outEn));
    c_past:  cover property (q.st == ST_RDATA && q.shift == INVALID_BYTE);
endmodule : gbi_target
